/* File: core/sdct_pkg.sv */
// Constants, command codes and types shared by the command timing controller.
package sdct_pkg;

  localparam int CLK_NS = 50;

  // Least times round up, longest times round down, never below one cycle.
  function automatic int cyc_min(input int ns);
    cyc_min = (ns + CLK_NS - 1) / CLK_NS;
    if (cyc_min < 1) cyc_min = 1;
  endfunction : cyc_min

  function automatic int cyc_max(input int ns);
    cyc_max = ns / CLK_NS;
    if (cyc_max < 1) cyc_max = 1;
  endfunction : cyc_max

  localparam int T_RC_NS      = 60;
  localparam int T_RAS_MIN_NS = 42;
  localparam int T_RAS_MAX_NS = 100000;
  localparam int T_RCD_COM_NS = 15;
  localparam int T_RCD_EXT_NS = 18;
  localparam int T_RP_COM_NS  = 15;
  localparam int T_RP_EXT_NS  = 18;
  localparam int T_XSR_NS     = 72;
  localparam int T_REF_COM_NS = 64000000;
  localparam int T_REF_HOT_NS = 16000000;
  localparam int REF_ROWS     = 8192;

  localparam int RC_CYC      = cyc_min(T_RC_NS);
  localparam int RAS_MIN_CYC = cyc_min(T_RAS_MIN_NS);
  localparam int RAS_MAX_CYC = cyc_max(T_RAS_MAX_NS);
  localparam int XSR_CYC     = cyc_min(T_XSR_NS);
  localparam int RRD_CYC     = 2;
  localparam int MRD_CYC     = 2;
  localparam int REF_COM_CYC = cyc_max(T_REF_COM_NS / REF_ROWS);
  localparam int REF_HOT_CYC = cyc_max(T_REF_HOT_NS / REF_ROWS);
  // Forced precharge is issued this many cycles ahead of the row limit.
  localparam int RAS_GUARD   = 8;

  localparam int TW         = 12;
  localparam int REF_W      = 8;
  localparam int BANK_W     = 2;
  localparam int NBANK      = 4;
  localparam int ADDR_W     = 13;
  localparam int ADDR_AP_BIT = 10;

  // Pin command codes: chip select, row strobe, column strobe, write enable.
  typedef logic [3:0] sdct_cmd_t;
  localparam sdct_cmd_t CMD_NOP = 4'h7;
  localparam sdct_cmd_t CMD_ACT = 4'h3;
  localparam sdct_cmd_t CMD_RD  = 4'h5;
  localparam sdct_cmd_t CMD_WR  = 4'h4;
  localparam sdct_cmd_t CMD_PRE = 4'h2;
  localparam sdct_cmd_t CMD_REF = 4'h1;
  localparam sdct_cmd_t CMD_MRS = 4'h0;

  typedef enum logic [3:0] {
    REQ_NOP = 4'h0,
    REQ_ACT = 4'h1,
    REQ_RD  = 4'h2,
    REQ_WR  = 4'h3,
    REQ_PRE = 4'h4,
    REQ_MRS = 4'h5,
    REQ_PDN = 4'h6,
    REQ_PUP = 4'h7,
    REQ_SRE = 4'h8,
    REQ_SRX = 4'h9
  } sdct_req_e;

  typedef enum logic [4:0] {
    ST_RUN = 5'h01,
    ST_PD  = 5'h02,
    ST_PDX = 5'h04,
    ST_SR  = 5'h08,
    ST_SRX = 5'h10
  } sdct_state_e;

endpackage : sdct_pkg

/* File: core/sdct_bank_if.sv */
// Per-bank event and permission signals between controller and bank timer.
`timescale 1ns/1ps
`default_nettype none
interface sdct_bank_if;
  logic act;
  logic pre;
  logic rw;
  logic act_ok;
  logic rw_ok;
  logic pre_ok;
  logic is_open;
  logic ras_due;
  modport timer (input act, pre, rw,
                 output act_ok, rw_ok, pre_ok, is_open, ras_due);
  modport ctrl  (output act, pre, rw,
                 input act_ok, rw_ok, pre_ok, is_open, ras_due);
endinterface : sdct_bank_if
`default_nettype wire

/* File: core/sdct_bank_timer.sv */
// Row timers of one bank: open state and its down-counters.
`timescale 1ns/1ps
`default_nettype none
module sdct_bank_timer #(
  parameter bit EXT_GRADE = 1'b0
) (
  // Clock and reset.
  input wire logic    mclk,
  input wire logic    reset,
  // Controller side.
  sdct_bank_if.timer  bif
);
  import sdct_pkg::*;

  localparam int RCD_CYC = cyc_min(EXT_GRADE ? T_RCD_EXT_NS : T_RCD_COM_NS);
  localparam int RP_CYC  = cyc_min(EXT_GRADE ? T_RP_EXT_NS : T_RP_COM_NS);

  if (RCD_CYC > 4 || RP_CYC > 4 || RAS_MIN_CYC > 4 ||
      RAS_MAX_CYC - RAS_GUARD >= 2 ** TW || RAS_MAX_CYC <= RAS_GUARD) begin : g_chk
    $error("bank timer counters cannot hold the clock rate");
  end

  typedef struct packed {
    logic          open;
    logic [1:0]    rcd;
    logic [1:0]    ras_min;
    logic [TW-1:0] ras_max;
    logic [1:0]    rp;
  } sdct_bank_s;

  sdct_bank_s q;
  sdct_bank_s d;

  always_comb begin
    d = q;
    if (q.rcd != 2'h0) d.rcd = q.rcd - 2'h1;
    if (q.ras_min != 2'h0) d.ras_min = q.ras_min - 2'h1;
    if (q.ras_max != '0) d.ras_max = q.ras_max - TW'(1);
    if (q.rp != 2'h0) d.rp = q.rp - 2'h1;
    if (bif.act) begin
      d.open    = 1'b1;
      d.rcd     = 2'(RCD_CYC - 1);                     // RULE_03 RULE_15
      d.ras_min = 2'(RAS_MIN_CYC - 1);                 // RULE_02 RULE_15
      d.ras_max = TW'(RAS_MAX_CYC - RAS_GUARD);        // RULE_02
    end
    if (bif.pre) begin
      d.open = 1'b0;
      d.rp   = 2'(RP_CYC - 1);                         // RULE_04 RULE_15
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) q <= '0;
    else q <= d;
  end

  assign bif.is_open = q.open;
  assign bif.act_ok  = !q.open && q.rp == 2'h0;        // RULE_04
  assign bif.rw_ok   = q.open && q.rcd == 2'h0;        // RULE_03
  assign bif.pre_ok  = q.ras_min == 2'h0;              // RULE_02
  assign bif.ras_due = q.open && q.ras_max == '0;      // RULE_02

  // Cycles the row has stayed open, watched against the row limit.
  logic [TW:0] open_age;
  always_ff @(posedge mclk) begin
    if (reset || !q.open) open_age <= '0;
    else if (open_age != '1) open_age <= open_age + 1'b1;
  end

  a_rw_open:   assert property (@(posedge mclk) disable iff (reset) // RULE_03
    bif.rw |-> q.open && q.rcd == 2'h0)
    else $error("read or write to a bank not yet open");
  a_ras_min:   assert property (@(posedge mclk) disable iff (reset) // RULE_02
    bif.pre |-> q.open && q.ras_min == 2'h0)
    else $error("precharge too soon after activate");
  a_rp_gap:    assert property (@(posedge mclk) disable iff (reset) // RULE_04
    bif.act |-> !q.open && q.rp == 2'h0)
    else $error("activate too soon after precharge");
  a_ras_limit: assert property (@(posedge mclk) disable iff (reset) // RULE_02
    q.open |-> open_age < (TW+1)'(RAS_MAX_CYC))
    else $error("row left open beyond the longest active time");

endmodule : sdct_bank_timer
`default_nettype wire

/* File: core/sdct_ctrl.sv */
// Host-side command timing controller that drives the memory pins.
// Operation
// RULE_01: Activate or refresh commands spaced at least 60 ns apart.
// RULE_02: Precharge no sooner than 42 ns, no later than 100000 ns.
// RULE_03: Read or write at least 15 ns, extended 18 ns, after activate.
// RULE_04: Activate at least 15 ns, extended 18 ns, after precharge.
// RULE_05: Activates to different banks at least two cycles apart.
// RULE_06: Two cycles pass after a mode register set.
// RULE_07: At least 72 ns from self refresh exit to activate.
// RULE_08: 8K refreshes per 64 ms, per 16 ms when hot; the hot rate is used only when EXT_GRADE is set.
// RULE_09: Power-down is entered by driving clock enable low.
// RULE_10: In power-down the device ignores command and data pins.
// RULE_11: First edge after clock enable rises carries a no-operation.
// RULE_12: Refresh interval is still met during power-down.
// RULE_13: Power-down during a burst becomes clock suspend instead.
// RULE_14: Device decodes using clock enable now and one cycle before.
// RULE_15: Nanosecond minimums round up into per-bank down-counters.
// RULE_16: Refresh is scheduled evenly by a periodic counter.
`timescale 1ns/1ps
`default_nettype none
module sdct_ctrl #(
  parameter bit EXT_GRADE = 1'b0
) (
  // Clock and reset.
  input  wire logic                       mclk,
  input  wire logic                       reset,
  // Command requests.
  input  wire logic                       req_valid,
  input  wire sdct_pkg::sdct_req_e        req_cmd,
  input  wire logic [sdct_pkg::BANK_W-1:0] req_bank,
  input  wire logic [sdct_pkg::ADDR_W-1:0] req_addr,
  output logic                            req_ready,
  // Temperature above the commercial limit, asynchronous.
  input  wire logic                       hot,
  // Memory pins.
  output logic                            sd_cke,
  output logic                            sd_cs_n,
  output logic                            sd_ras_n,
  output logic                            sd_cas_n,
  output logic                            sd_we_n,
  output logic [sdct_pkg::BANK_W-1:0]     sd_ba,
  output logic [sdct_pkg::ADDR_W-1:0]     sd_addr,
  // Status.
  output logic                            in_pd,
  output logic                            in_sr
);
  import sdct_pkg::*;

  if (RC_CYC > 4 || XSR_CYC > 4 || REF_COM_CYC >= 2 ** REF_W ||
      REF_HOT_CYC < 1) begin : g_chk
    $error("controller counters cannot hold the clock rate");
  end

  typedef struct packed {
    sdct_state_e          state;
    logic                 hold_v;
    sdct_req_e            hold_cmd;
    logic [BANK_W-1:0]    hold_bank;
    logic [ADDR_W-1:0]    hold_addr;
    logic                 ready;
    logic                 cke;
    sdct_cmd_t            cmd;
    logic [BANK_W-1:0]    ba;
    logic [ADDR_W-1:0]    addr;
    logic [1:0]           rc;
    logic [1:0]           rrd;
    logic [1:0]           mrd;
    logic [1:0]           xsr;
    logic [REF_W-1:0]     ref_cnt;
    logic                 ref_pend;
    logic                 pd_resume;
    logic                 hot_s1;
    logic                 hot_s2;
  } sdct_ctrl_s;

  sdct_ctrl_s       q;
  sdct_ctrl_s       d;
  logic [NBANK-1:0] act_v, pre_v, rw_v;
  logic [NBANK-1:0] act_ok_v, rw_ok_v, pre_ok_v, open_v, due_v;

  sdct_bank_if bif [NBANK] ();

  for (genvar g = 0; g < NBANK; g++) begin : g_bank
    assign bif[g].act  = act_v[g];
    assign bif[g].pre  = pre_v[g];
    assign bif[g].rw   = rw_v[g];
    assign act_ok_v[g] = bif[g].act_ok;
    assign rw_ok_v[g]  = bif[g].rw_ok;
    assign pre_ok_v[g] = bif[g].pre_ok;
    assign open_v[g]   = bif[g].is_open;
    assign due_v[g]    = bif[g].ras_due;
    sdct_bank_timer #(.EXT_GRADE(EXT_GRADE)) u_timer (
      .mclk  (mclk),
      .reset (reset),
      .bif   (bif[g])
    );
  end

  logic all_idle;
  logic pall_ok;
  logic [REF_W-1:0] ref_load;
  assign all_idle = open_v == '0 && act_ok_v == '1 && q.rc == 2'h0;
  assign pall_ok  = (pre_ok_v | ~open_v) == '1;
  assign ref_load = (EXT_GRADE && q.hot_s2) ? REF_W'(REF_HOT_CYC - 1)
                                            : REF_W'(REF_COM_CYC - 1);

  always_comb begin
    d = q;
    act_v = '0;
    pre_v = '0;
    rw_v  = '0;
    d.hot_s1 = hot;
    d.hot_s2 = q.hot_s1;
    d.cmd = CMD_NOP;
    d.cke = 1'b1;
    if (q.rc != 2'h0) d.rc = q.rc - 2'h1;
    if (q.rrd != 2'h0) d.rrd = q.rrd - 2'h1;
    if (q.mrd != 2'h0) d.mrd = q.mrd - 2'h1;
    if (q.xsr != 2'h0) d.xsr = q.xsr - 2'h1;
    // Periodic refresh tick; outside self refresh a tick wins over a clear in the same cycle.
    if (q.ref_cnt == '0) d.ref_cnt = ref_load;             // RULE_16 RULE_08
    else d.ref_cnt = q.ref_cnt - REF_W'(1);
    if (!q.hold_v && req_valid && q.ready) begin
      d.hold_v    = 1'b1;
      d.hold_cmd  = req_cmd;
      d.hold_bank = req_bank;
      d.hold_addr = req_addr;
    end
    case (q.state)
      ST_RUN: begin
        if (q.mrd != 2'h0) begin
          d.cmd = CMD_NOP;                                  // RULE_06
        end else if ((q.ref_pend || due_v != '0) && open_v != '0) begin
          if (pall_ok) begin
            d.cmd = CMD_PRE;                                // RULE_02
            d.addr[ADDR_AP_BIT] = 1'b1;
            pre_v = open_v;
          end
        end else if (q.ref_pend) begin
          if (all_idle) begin
            d.cmd = CMD_REF;                                // RULE_01 RULE_08
            d.rc = 2'(RC_CYC - 1);
            d.ref_pend = 1'b0;
          end
        end else if (q.pd_resume) begin
          d.cke = 1'b0;                                     // RULE_12
          d.pd_resume = 1'b0;
          d.state = ST_PD;
        end else if (q.hold_v) begin
          d.hold_v = 1'b0;
          d.ba = q.hold_bank;
          d.addr = q.hold_addr;
          case (q.hold_cmd)
            REQ_ACT: begin
              if (act_ok_v[q.hold_bank] && q.rc == 2'h0 && q.rrd == 2'h0
                  && q.xsr == 2'h0) begin
                d.cmd = CMD_ACT;                            // RULE_01 RULE_05
                d.rc  = 2'(RC_CYC - 1);
                d.rrd = 2'(RRD_CYC - 1);                    // RULE_05
                act_v[q.hold_bank] = 1'b1;
              end else d.hold_v = 1'b1;
            end
            REQ_RD, REQ_WR: begin
              if (rw_ok_v[q.hold_bank]) begin
                d.cmd = (q.hold_cmd == REQ_RD) ? CMD_RD : CMD_WR; // RULE_03
                d.addr[ADDR_AP_BIT] = 1'b0;
                rw_v[q.hold_bank] = 1'b1;
              end else d.hold_v = open_v[q.hold_bank];
            end
            REQ_PRE: begin
              if (pre_ok_v[q.hold_bank]) begin
                d.cmd = CMD_PRE;                            // RULE_02
                d.addr[ADDR_AP_BIT] = 1'b0;
                pre_v[q.hold_bank] = open_v[q.hold_bank];
              end else d.hold_v = 1'b1;
            end
            REQ_MRS: begin
              if (all_idle) begin
                d.cmd = CMD_MRS;
                d.mrd = 2'(MRD_CYC - 1);                    // RULE_06
              end else d.hold_v = 1'b1;
            end
            REQ_PDN: begin
              if (q.ref_cnt != '0) begin
                d.cke = 1'b0;                               // RULE_09 RULE_13
                d.state = ST_PD;
              end else d.hold_v = 1'b1;
            end
            REQ_SRE: begin
              if (all_idle) begin
                d.cmd = CMD_REF;                            // RULE_01
                d.rc = 2'(RC_CYC - 1);
                d.cke = 1'b0;
                d.state = ST_SR;
              end else d.hold_v = 1'b1;
            end
            default: d.cmd = CMD_NOP;
          endcase
        end
      end
      ST_PD: begin
        d.cke = 1'b0;                                       // RULE_10
        if (q.hold_v) d.hold_v = 1'b0;
        if (q.ref_pend || (q.hold_v && q.hold_cmd == REQ_PUP)) begin
          d.cke = 1'b1;                                     // RULE_12 RULE_14
          d.pd_resume = !(q.hold_v && q.hold_cmd == REQ_PUP);
          d.state = ST_PDX;
        end
      end
      ST_PDX: begin
        d.cmd = CMD_NOP;                                    // RULE_11
        d.state = ST_RUN;
      end
      ST_SR: begin
        d.cke = 1'b0;
        d.ref_pend = 1'b0;
        d.ref_cnt = ref_load;
        if (q.hold_v) d.hold_v = 1'b0;
        if (q.hold_v && q.hold_cmd == REQ_SRX) begin
          d.cke = 1'b1;                                     // RULE_14
          d.xsr = 2'(XSR_CYC - 1);                          // RULE_07
          d.state = ST_SRX;
        end
      end
      ST_SRX: begin
        d.cmd = CMD_NOP;                                    // RULE_11
        if (q.xsr == 2'h0) d.state = ST_RUN;                // RULE_07
      end
      default: d.state = ST_RUN;
    endcase
    if (q.ref_cnt == '0 && q.state != ST_SR) d.ref_pend = 1'b1; // RULE_12
    d.ready = !d.hold_v;
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      q <= '0;
      q.state <= ST_RUN;
      q.hold_cmd <= REQ_NOP;
      q.cke <= 1'b1;
      q.cmd <= CMD_NOP;
      q.ready <= 1'b1;
      q.ref_cnt <= REF_W'(REF_COM_CYC - 1);
    end else begin
      q <= d;
    end
  end

  assign req_ready = q.ready;
  assign sd_cke    = q.cke;
  assign {sd_cs_n, sd_ras_n, sd_cas_n, sd_we_n} = q.cmd;
  assign sd_ba     = q.ba;
  assign sd_addr   = q.addr;
  // One-hot state bits drive the status pins straight from the register.
  assign in_pd     = q.state[1];
  assign in_sr     = q.state[3];

  // Cycles since the last refresh, outside self refresh.
  logic [REF_W+1:0] since_ref;
  always_ff @(posedge mclk) begin
    if (reset || q.cmd == CMD_REF || q.state == ST_SR) since_ref <= '0;
    else if (since_ref != '1) since_ref <= since_ref + 1'b1;
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  sequence s_act_ref;
    q.cmd == CMD_ACT || q.cmd == CMD_REF;
  endsequence
  sequence s_wake;
    $rose(q.cke);
  endsequence
  sequence s_two_nops;
    q.cmd == CMD_NOP ##1 q.cmd == CMD_NOP;
  endsequence

  a_rc_spacing:  assert property (s_act_ref |=> !(q.cmd == CMD_ACT || // RULE_01
    q.cmd == CMD_REF))
    else $error("activate or refresh spaced below 60 ns");
  a_rrd_spacing: assert property (q.cmd == CMD_ACT |=> q.cmd != CMD_ACT) // RULE_05
    else $error("activates closer than two cycles");
  a_mrd_wait:    assert property (q.cmd == CMD_MRS |=> q.cmd == CMD_NOP) // RULE_06
    else $error("command issued within two cycles of mode set");
  a_wake_nop:    assert property (s_wake |-> s_two_nops) // RULE_11
    else $error("clock enable rise not followed by no-operation");
  a_cke_low:     assert property ($fell(q.cke) |-> // RULE_09
    (q.state == ST_PD || q.state == ST_SR) ##1 !q.cke)
    else $error("clock enable dropped outside power-down");
  a_xsr_wait:    assert property (s_wake ##0 q.state == ST_SRX |-> // RULE_07
    q.cmd != CMD_ACT ##1 q.cmd != CMD_ACT)
    else $error("activate too soon after self refresh exit");
  a_ref_budget:  assert property (since_ref <= (REF_W+2)'(REF_COM_CYC + 16)) // RULE_08
    else $error("refresh interval exceeded");

endmodule : sdct_ctrl
`default_nettype wire

/* File: verification/sdct_dev_model.sv */
// Behavioural memory device that counts command timing violations.
`timescale 1ns/1ps
`default_nettype none
module sdct_dev_model
  import sdct_pkg::*;
(
  // Clock and reset.
  input  wire logic                mclk,
  input  wire logic                reset,
  // Memory pins.
  input  wire logic                sd_cke,
  input  wire logic                sd_cs_n,
  input  wire logic                sd_ras_n,
  input  wire logic                sd_cas_n,
  input  wire logic                sd_we_n,
  input  wire logic [BANK_W-1:0]   sd_ba,
  input  wire logic [ADDR_W-1:0]   sd_addr,
  // Case temperature above the commercial limit.
  input  wire logic                hot,
  // Observation.
  output logic      [15:0]         viol,
  output logic      [15:0]         n_ref,
  output logic      [NBANK-1:0]    bank_open
);
  localparam int CK     = 50;
  localparam int RC     = (60 + CK - 1) / CK;
  localparam int RAS_MN = (42 + CK - 1) / CK;
  localparam int RAS_MX = 100000 / CK;
  localparam int RCD    = (18 + CK - 1) / CK;
  localparam int RP     = (18 + CK - 1) / CK;
  localparam int XSR    = (72 + CK - 1) / CK;
  localparam int REF_C  = 64000000 / 8192 / CK;
  localparam int REF_H  = 16000000 / 8192 / CK;

  int        cyc = 0, last_rc = -99, last_any = -99, last_mrs = -99;
  int        last_srx = -99, last_ref = 0, hot_age = 0;
  int        last_act[NBANK], last_pre[NBANK];
  logic      cke_q = 1'b1, hot_q = 1'b0, in_sr = 1'b0;
  sdct_cmd_t cmd;
  int        b;

  always @(posedge mclk) begin
    cyc++;
    cmd = sd_cs_n ? CMD_NOP : {sd_cs_n, sd_ras_n, sd_cas_n, sd_we_n};
    b = int'(sd_ba);
    hot_age = (hot === hot_q) ? hot_age + 1 : 0;
    hot_q = hot;
    if (reset) begin
      viol = '0;
      n_ref = '0;
      for (int i = 0; i < NBANK; i++) begin
        last_act[i] = -99;
        last_pre[i] = -99;
      end
      bank_open = '0;
      in_sr = 1'b0;
      cke_q = 1'b1;
      last_ref = cyc;
    end else begin
      // Commands decode only when clock enable was high one edge earlier.
      if (cke_q) begin
        if (cmd != CMD_NOP && cyc - last_mrs < 2) viol++;
        case (cmd)
          CMD_ACT: begin
            if (bank_open[b] || cyc - last_rc < RC || cyc - last_any < 2 ||
                cyc - last_pre[b] < RP || cyc - last_srx < XSR)
              viol++;
            bank_open[b] = 1'b1;
            last_act[b] = cyc;
            last_any = cyc;
            last_rc = cyc;
          end
          CMD_RD, CMD_WR: begin
            if (!bank_open[b] || cyc - last_act[b] < RCD) viol++;
          end
          CMD_PRE: begin
            for (int i = 0; i < NBANK; i++) begin
              if ((sd_addr[ADDR_AP_BIT] || i == b) && bank_open[i]) begin
                if (cyc - last_act[i] < RAS_MN) viol++;
                bank_open[i] = 1'b0;
                last_pre[i] = cyc;
              end
            end
          end
          CMD_REF: begin
            if (bank_open != '0 || cyc - last_rc < RC) viol++;
            for (int i = 0; i < NBANK; i++)
              if (cyc - last_pre[i] < RP) viol++;
            last_rc = cyc;
            last_ref = cyc;
            n_ref++;
            in_sr = !sd_cke;
          end
          CMD_MRS: last_mrs = cyc;
          default: ;
        endcase
      end else if (sd_cke && cmd != CMD_NOP) begin
        viol++;
      end
      if (!cke_q && sd_cke && in_sr) begin
        in_sr = 1'b0;
        last_srx = cyc;
        last_ref = cyc;
      end
      for (int i = 0; i < NBANK; i++)
        if (bank_open[i] && cyc - last_act[i] > RAS_MX) viol++;
      // The hot rate only binds once the raised flag has settled.
      if (!in_sr && cyc - last_ref >
          ((hot && hot_age > 400) ? 2 * REF_H : 2 * REF_C))
        viol++;
      cke_q = sd_cke;
    end
  end
endmodule : sdct_dev_model
`default_nettype wire

/* File: verification/sdct_ctrl_bench.sv */
// Self-checking bench of the command timing controller.
`timescale 1ns/1ps
`default_nettype none
module sdct_ctrl_bench;
  import sdct_pkg::*;

  logic                mclk = 1'b0, reset = 1'b1, hot = 1'b0;
  logic                req_valid = 1'b0, req_ready;
  sdct_req_e           req_cmd = REQ_NOP;
  logic [BANK_W-1:0]   req_bank = '0;
  logic [ADDR_W-1:0]   req_addr = '0;
  logic                sd_cke, sd_cs_n, sd_ras_n, sd_cas_n, sd_we_n;
  logic [BANK_W-1:0]   sd_ba;
  logic [ADDR_W-1:0]   sd_addr;
  logic                in_pd, in_sr;
  logic [15:0]         viol, n_ref, r0;
  logic [NBANK-1:0]    bank_open;
  int                  n_errors = 0, comparisons = 0, cycles = 0;
  logic [BANK_W-1:0]   b;
  sdct_req_e           seq[5] = '{REQ_MRS, REQ_ACT, REQ_RD, REQ_WR, REQ_PRE};

  always #25 mclk = ~mclk;

  sdct_ctrl #(.EXT_GRADE(1'b1)) sdct_ctrl_i (
    .mclk(mclk), .reset(reset), .req_valid(req_valid), .req_cmd(req_cmd),
    .req_bank(req_bank), .req_addr(req_addr), .req_ready(req_ready),
    .hot(hot), .sd_cke(sd_cke), .sd_cs_n(sd_cs_n), .sd_ras_n(sd_ras_n),
    .sd_cas_n(sd_cas_n), .sd_we_n(sd_we_n), .sd_ba(sd_ba),
    .sd_addr(sd_addr), .in_pd(in_pd), .in_sr(in_sr));

  sdct_dev_model sdct_dev_model_i (
    .mclk(mclk), .reset(reset), .sd_cke(sd_cke), .sd_cs_n(sd_cs_n),
    .sd_ras_n(sd_ras_n), .sd_cas_n(sd_cas_n), .sd_we_n(sd_we_n),
    .sd_ba(sd_ba), .sd_addr(sd_addr), .hot(hot), .viol(viol),
    .n_ref(n_ref), .bank_open(bank_open));

  function automatic sdct_cmd_t exp_pin(input sdct_req_e r);
    case (r)
      REQ_ACT: exp_pin = CMD_ACT;
      REQ_RD:  exp_pin = CMD_RD;
      REQ_WR:  exp_pin = CMD_WR;
      REQ_PRE: exp_pin = CMD_PRE;
      REQ_MRS: exp_pin = CMD_MRS;
      default: exp_pin = CMD_NOP;
    endcase
  endfunction : exp_pin

  // Refresh commands expected in a span, one short for phase.
  function automatic int exp_refs(input int span, input logic h);
    exp_refs = span / ((h ? 16000000 : 64000000) / 8192 / 50) - 1;
  endfunction : exp_refs

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic report_and_stop;
    $display("errors=%0d comparisons=%0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : report_and_stop

  task automatic issue(input sdct_req_e c, input logic [BANK_W-1:0] bk,
                       input logic [ADDR_W-1:0] a);
    int n;
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while (req_ready !== 1'b1 && n < 3000);
    check(n < 3000, 1'b1);
    @(posedge mclk);
    req_valid <= 1'b1;
    req_cmd   <= c;
    req_bank  <= bk;
    req_addr  <= a;
    @(posedge mclk);
    req_valid <= 1'b0;
  endtask : issue

  task automatic expect_pin(input sdct_cmd_t c, input int lim);
    int   n;
    logic hit;
    n = 0;
    hit = 1'b0;
    while (!hit && n < lim) begin
      @(negedge mclk);
      hit = ({sd_cs_n, sd_ras_n, sd_cas_n, sd_we_n} === c);
      n++;
    end
    check(hit, 1'b1);
  endtask : expect_pin

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 40000) begin
      n_errors++;
      report_and_stop();
    end
  end

  initial begin
    void'($urandom(80));
    repeat (6) @(posedge mclk);
    reset <= 1'b0;
    @(negedge mclk);
    check({sd_cke, sd_cs_n, sd_ras_n, sd_cas_n, sd_we_n, req_ready,
           in_pd, in_sr}, 8'hbc);
    for (int i = 0; i < 5; i++) begin
      issue(seq[i], 2'h1, 13'h0);
      expect_pin(exp_pin(seq[i]), 400);
    end
    // Back-to-back activates, then close both banks.
    issue(REQ_ACT, 2'h0, 13'h1);
    issue(REQ_ACT, 2'h1, 13'h2);
    issue(REQ_PRE, 2'h0, 13'h400);
    issue(REQ_PRE, 2'h1, 13'h0);
    repeat (6) @(negedge mclk);
    check(bank_open, 4'h0);
    // Power-down with a refresh falling due inside it.
    issue(REQ_PDN, 2'h0, 13'h0);
    repeat (2) @(negedge mclk);
    check({sd_cke, in_pd}, 2'b01);
    issue(REQ_ACT, 2'h2, 13'h0);
    repeat (400) @(negedge mclk);
    check(bank_open, 4'h0);
    issue(REQ_PUP, 2'h0, 13'h0);
    repeat (3) @(negedge mclk);
    check({sd_cke, in_pd}, 2'b10);
    // Self refresh, then an immediate activate on exit.
    issue(REQ_SRE, 2'h0, 13'h0);
    repeat (3) @(negedge mclk);
    check({sd_cke, in_sr}, 2'b01);
    repeat (300) @(posedge mclk);
    issue(REQ_SRX, 2'h0, 13'h0);
    issue(REQ_ACT, 2'h3, 13'h5);
    expect_pin(CMD_ACT, 50);
    check(in_sr, 1'b0);
    issue(REQ_PRE, 2'h3, 13'h0);
    // Random open, access and close sequences.
    repeat (60) begin
      b = BANK_W'($urandom_range(3));
      hot <= ($urandom_range(7) == 0);
      issue(REQ_ACT, b, ADDR_W'($urandom));
      repeat ($urandom_range(3)) begin
        repeat (2) @(negedge mclk);
        if (!bank_open[b]) issue(REQ_ACT, b, ADDR_W'($urandom));
        issue($urandom_range(1) ? REQ_RD : REQ_WR, b,
              ADDR_W'($urandom) & 13'h1bff);
      end
      issue(REQ_PRE, b, 13'h0);
      repeat ($urandom_range(4)) @(posedge mclk);
    end
    // Refresh rate when cool and when hot.
    hot <= 1'b0;
    repeat (400) @(posedge mclk);
    r0 = n_ref;
    repeat (1560) @(posedge mclk);
    check(32'(n_ref - r0) >= exp_refs(1560, 1'b0), 1'b1);
    hot <= 1'b1;
    repeat (500) @(posedge mclk);
    r0 = n_ref;
    repeat (390) @(posedge mclk);
    check(32'(n_ref - r0) >= exp_refs(390, 1'b1), 1'b1);
    check(viol, 16'h0);
    report_and_stop();
  end
endmodule : sdct_ctrl_bench
`default_nettype wire
